// ### inc/mpu_pkg.sv
// Purpose: Shared constants and carrier types for the protection error capture block
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, 12 address bits
// Notes: Region and port counts are fixed here because the state struct is sized by them
package mpu_pkg;
   localparam int NUM_PORTS = 4;
   localparam int NUM_REGIONS = 8;
   localparam int ADDR_W = 12;
   localparam int CORE_MASTERS = 4;
   // Register map, byte offsets
   localparam logic [11:0] CTRL_OFF = 12'h000;
   localparam logic [11:0] IRQ_STAT_OFF = 12'h040;
   localparam logic [11:0] IRQ_CLR_OFF = 12'h044;
   localparam logic [11:0] IRQ_EN_OFF = 12'h048;
   localparam logic [11:0] ERR_BASE = 12'h100;
   localparam logic [11:0] ERR_STRIDE = 12'h008;
   localparam logic [11:0] EDR_SUB = 12'h004;
   localparam logic [11:0] RGD_BASE = 12'h400;
   localparam logic [11:0] RGD_STRIDE = 12'h010;
   // Control word fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_FLAG_LSB = 24;
   localparam logic CTRL_EN_RST = 1'b0;
   // Error detail fields
   localparam int EDR_DIR_BIT = 0;
   localparam int EDR_ATTR_LSB = 1;
   localparam int EDR_MASTER_LSB = 4;
   localparam int EDR_PID_LSB = 8;
   localparam int EDR_HIT_LSB = 16;
   // Descriptor layout
   localparam int ADDR_LSB = 5;
   localparam int VALID_BIT = 0;
   localparam logic [1:0] WORD_START = 2'd0;
   localparam logic [1:0] WORD_END = 2'd1;
   localparam logic [1:0] WORD_CTRL = 2'd3;
   localparam logic [2:0] ATTR_SUPER_DATA = 3'h3;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic write;
      logic [3:0] master;
      logic [7:0] pid;
      logic supervisor;
      logic instr;
   } ref_t;

   typedef struct packed {
      logic [31:ADDR_LSB] start;
      logic [31:ADDR_LSB] finish;
      logic valid;
   } region_t;

   typedef struct packed {
      logic glob_en;
      logic [NUM_PORTS-1:0] flag;
      logic [NUM_PORTS-1:0][31:0] ear;
      logic [NUM_PORTS-1:0][31:0] edr;
      region_t [NUM_REGIONS-1:0] rgn;
      logic [NUM_PORTS-1:0] irq_stat;
      logic [NUM_PORTS-1:0] irq_en;
      logic ack;
      logic [31:0] rdata;
      logic [1:0] resp;
   } state_t;
endpackage : mpu_pkg

// ### core/mpu_err_rgn.sv
// Purpose: Per-port error capture and region start/end words of a memory protection unit
// Assumes: References and access-denial vectors arrive from logic on clk; Avalon-MM slave
// Notes: Word 2 access rights live elsewhere and arrive as the deny input
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module mpu_err_rgn
   import mpu_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic [1:0] avs_response,
   output logic avs_waitrequest,
   input wire ref_t [NUM_PORTS-1:0] port_ref,
   input wire logic [NUM_PORTS-1:0][NUM_REGIONS-1:0] port_deny,
   output logic [NUM_PORTS-1:0] port_fault,
   output logic [NUM_REGIONS-1:0] region_valid,
   output logic irq
);
   state_t q, d;
   logic [NUM_PORTS-1:0] err;
   logic [NUM_PORTS-1:0][NUM_REGIONS-1:0] hit;
   logic req;
   logic wr_now;

   function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge_be

   function automatic logic in_region(input region_t r, input logic [31:0] a);
      // No ordering check on start/end; an inverted pair simply never hits
      return r.valid && (a[31:ADDR_LSB] >= r.start) && (a[31:ADDR_LSB] <= r.finish);
   endfunction : in_region

   function automatic logic [31:0] detail(input ref_t r, input logic [NUM_REGIONS-1:0] hv);
      logic [31:0] w;
      logic core;
      w = '0;
      core = (r.master < 4'(CORE_MASTERS));
      w[EDR_HIT_LSB +: NUM_REGIONS] = hv;
      w[EDR_PID_LSB +: 8] = core ? r.pid : 8'h00;
      w[EDR_MASTER_LSB +: 4] = r.master;
      w[EDR_ATTR_LSB +: 3] = core ? {1'b0, r.supervisor, ~r.instr} : ATTR_SUPER_DATA;
      w[EDR_DIR_BIT] = r.write;
      return w;
   endfunction : detail

   // Access passes if any hit region grants it; miss or all-denied hits fault
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         for (int g = 0; g < NUM_REGIONS; g++) begin
            hit[p][g] = in_region(q.rgn[g], port_ref[p].addr);
         end
         err[p] = q.glob_en && port_ref[p].valid && ~|(hit[p] & ~port_deny[p]);
      end
   end

   assign req = avs_read | avs_write;
   assign wr_now = avs_write & q.ack;
   assign avs_waitrequest = req & ~q.ack;
   assign avs_readdata = q.rdata;
   assign avs_response = q.resp;
   assign port_fault = err;
   assign irq = |(q.irq_stat & q.irq_en);

   always_comb begin
      logic [31:0] rd;
      logic mapped;
      logic [11:0] rel;
      logic [11:0] eoff;
      logic [31:0] cur;
      logic [31:0] nw;
      rd = '0;
      mapped = 1'b0;
      rel = '0;
      eoff = '0;
      cur = '0;
      nw = '0;
      d = q;
      d.ack = req & ~q.ack;

      // Control and status word
      if (avs_address == CTRL_OFF) begin
         mapped = 1'b1;
         rd[CTRL_EN_BIT] = q.glob_en;
         rd[CTRL_FLAG_LSB +: NUM_PORTS] = q.flag;
         if (wr_now) begin
            nw = merge_be(rd, avs_writedata, avs_byteenable);
            d.glob_en = nw[CTRL_EN_BIT];
            d.flag = q.flag & ~(avs_writedata[CTRL_FLAG_LSB +: NUM_PORTS]
                     & {NUM_PORTS{avs_byteenable[3]}});
         end
      end

      // Interrupt status, clear and enable
      if (avs_address == IRQ_STAT_OFF) begin
         mapped = 1'b1;
         rd[NUM_PORTS-1:0] = q.irq_stat;
      end
      if (avs_address == IRQ_CLR_OFF) begin
         mapped = 1'b1;
         if (wr_now) begin
            d.irq_stat = q.irq_stat & ~avs_writedata[NUM_PORTS-1:0];
         end
      end
      if (avs_address == IRQ_EN_OFF) begin
         mapped = 1'b1;
         rd[NUM_PORTS-1:0] = q.irq_en;
         if (wr_now) begin
            nw = merge_be({{(32-NUM_PORTS){1'b0}}, q.irq_en}, avs_writedata, avs_byteenable);
            d.irq_en = nw[NUM_PORTS-1:0];
         end
      end

      // Per-port capture registers are read only; writes are accepted and dropped
      for (int p = 0; p < NUM_PORTS; p++) begin
         eoff = ERR_BASE + 12'(p) * ERR_STRIDE;
         if (avs_address == eoff) begin
            mapped = 1'b1;
            rd = q.ear[p];
         end
         if (avs_address == eoff + EDR_SUB) begin
            mapped = 1'b1;
            rd = q.edr[p];
         end
      end

      // Descriptors sit back to back, four words each
      for (int g = 0; g < NUM_REGIONS; g++) begin
         rel = avs_address - (RGD_BASE + 12'(g) * RGD_STRIDE);
         if (avs_address >= RGD_BASE + 12'(g) * RGD_STRIDE && rel < RGD_STRIDE
             && rel[1:0] == 2'b00) begin
            mapped = 1'b1;
            case (rel[3:2])
               WORD_START: begin
                  cur = {q.rgn[g].start, 5'h00};
                  rd = cur;
                  if (wr_now) begin
                     nw = merge_be(cur, avs_writedata, avs_byteenable);
                     d.rgn[g].start = nw[31:ADDR_LSB];
                     d.rgn[g].valid = 1'b0;
                  end
               end
               WORD_END: begin
                  cur = {q.rgn[g].finish, 5'h00};
                  rd = cur;
                  if (wr_now) begin
                     nw = merge_be(cur, avs_writedata, avs_byteenable);
                     d.rgn[g].finish = nw[31:ADDR_LSB];
                     d.rgn[g].valid = 1'b0;
                  end
               end
               WORD_CTRL: begin
                  rd[VALID_BIT] = q.rgn[g].valid;
                  if (wr_now && avs_byteenable[0]) begin
                     d.rgn[g].valid = avs_writedata[VALID_BIT];
                  end
               end
               default: begin
                  rd = '0;
               end
            endcase
         end
      end

      // Hardware capture after software clear, so a same-cycle error keeps its flag
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (err[p]) begin
            d.ear[p] = port_ref[p].addr;
            d.edr[p] = detail(port_ref[p], hit[p] & port_deny[p]);
            d.flag[p] = 1'b1;
            d.irq_stat[p] = 1'b1;
         end
      end

      if (req && !q.ack) begin
         d.rdata = avs_read ? rd : 32'h0000_0000;
         d.resp = mapped ? RESP_OK : RESP_SLVERR;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.glob_en <= CTRL_EN_RST;
      end else begin
         q <= d;
      end
   end

   always_comb begin
      for (int g = 0; g < NUM_REGIONS; g++) begin
         region_valid[g] = q.rgn[g].valid;
      end
   end

   // Checks
   logic acc_w;
   assign acc_w = avs_write & ~avs_waitrequest;

   AST_CAPTURE_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
      err[0] |=> q.flag[0] && irq_stat_set(0))
      else $error("Error on port 0 did not set its flag");

   function automatic logic irq_stat_set(input int p);
      return q.irq_stat[p];
   endfunction : irq_stat_set

   AST_EAR_WITH_EDR: assert property (@(posedge clk) disable iff (!rst_n)
      err[0] |=> q.ear[0] == $past(port_ref[0].addr)
                 && q.edr[0][EDR_MASTER_LSB +: 4] == $past(port_ref[0].master))
      else $error("Error address not captured with detail");

   AST_RELOAD_ALWAYS: assert property (@(posedge clk) disable iff (!rst_n)
      q.flag[0] && err[0] |=> q.ear[0] == $past(port_ref[0].addr))
      else $error("Capture not reloaded while flag set");

   AST_HIT_VECTOR: assert property (@(posedge clk) disable iff (!rst_n)
      err[0] |=> q.edr[0][EDR_HIT_LSB +: NUM_REGIONS] == $past(hit[0] & port_deny[0]))
      else $error("Hit vector not captured");

   AST_MISS_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
      err[0] && hit[0] == '0 |=> q.edr[0][EDR_HIT_LSB +: NUM_REGIONS] == '0)
      else $error("Miss left a nonzero hit vector");

   AST_NONCORE_FIELDS: assert property (@(posedge clk) disable iff (!rst_n)
      err[0] && port_ref[0].master >= 4'(CORE_MASTERS)
      |=> q.edr[0][EDR_PID_LSB +: 8] == 8'h00 && q.edr[0][EDR_ATTR_LSB +: 3] == ATTR_SUPER_DATA)
      else $error("Non-core fault fields wrong");

   AST_CORE_ATTR: assert property (@(posedge clk) disable iff (!rst_n)
      err[0] && port_ref[0].master < 4'(CORE_MASTERS) && port_ref[0].supervisor
      && !port_ref[0].instr |=> q.edr[0][EDR_ATTR_LSB +: 3] == 3'h3)
      else $error("Core attribute encoding wrong");

   AST_DIRECTION: assert property (@(posedge clk) disable iff (!rst_n)
      err[0] |=> q.edr[0][EDR_DIR_BIT] == $past(port_ref[0].write))
      else $error("Direction bit wrong");

   AST_W0_CLEARS_VALID: assert property (@(posedge clk) disable iff (!rst_n)
      acc_w && (avs_address == RGD_BASE || avs_address == RGD_BASE + 12'h004)
      |=> !region_valid[0])
      else $error("Start or end write left region valid");

   AST_LOW_BITS: assert property (@(posedge clk) disable iff (!rst_n)
      avs_read && avs_waitrequest && avs_address == RGD_BASE |=> avs_readdata[4:0] == 5'h00)
      else $error("Start word low bits not zero");

   AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
      acc_w && avs_address == CTRL_OFF && avs_byteenable[3]
      && avs_writedata[CTRL_FLAG_LSB] && err[0] |=> q.flag[0])
      else $error("Same-cycle error lost to clear");

   AST_CLEAR_ONE: assert property (@(posedge clk) disable iff (!rst_n)
      acc_w && avs_address == CTRL_OFF && avs_byteenable[3]
      && avs_writedata[CTRL_FLAG_LSB] && !err[0] |=> !q.flag[0])
      else $error("Write one did not clear flag");

   AST_DISABLED: assert property (@(posedge clk) disable iff (!rst_n)
      !q.glob_en |-> port_fault == '0)
      else $error("Fault raised while disabled");

   AST_WAIT_ONE: assert property (@(posedge clk) disable iff (!rst_n)
      avs_waitrequest |=> !avs_waitrequest)
      else $error("Request not answered after one wait cycle");

   AST_READ_STANDS: assert property (@(posedge clk) disable iff (!rst_n)
      q.ack |=> $stable(avs_readdata) && $stable(avs_response))
      else $error("Read answer changed after its ack cycle");

   AST_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n)
      avs_read && avs_waitrequest && avs_address >= RGD_BASE + 12'(NUM_REGIONS) * RGD_STRIDE
      |=> avs_response == RESP_SLVERR && avs_readdata == 32'h0000_0000)
      else $error("Unmapped read not refused");

   // Every port, not only port 0: capture, hold and field checks
   for (genvar gp = 0; gp < NUM_PORTS; gp++) begin : g_port_chk
      AST_PORT_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
         err[gp] |=> q.flag[gp] && q.irq_stat[gp])
         else $error("Port error did not set its flag");

      AST_PORT_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
         err[gp] |=> q.ear[gp] == $past(port_ref[gp].addr))
         else $error("Port error address not captured");

      AST_PORT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
         !err[gp] |=> $stable(q.ear[gp]) && $stable(q.edr[gp]))
         else $error("Capture registers changed without an error");

      AST_PORT_FLAG_SRC: assert property (@(posedge clk) disable iff (!rst_n)
         !q.flag[gp] && !err[gp] |=> !q.flag[gp])
         else $error("Port flag set without an error");

      AST_PORT_MASTER: assert property (@(posedge clk) disable iff (!rst_n)
         err[gp] |=> q.edr[gp][EDR_MASTER_LSB +: 4] == $past(port_ref[gp].master))
         else $error("Master number not captured");

      AST_PORT_PID: assert property (@(posedge clk) disable iff (!rst_n)
         err[gp] && port_ref[gp].master < 4'(CORE_MASTERS)
         |=> q.edr[gp][EDR_PID_LSB +: 8] == $past(port_ref[gp].pid))
         else $error("Core process id not captured");

      AST_PORT_NONCORE: assert property (@(posedge clk) disable iff (!rst_n)
         err[gp] && port_ref[gp].master >= 4'(CORE_MASTERS)
         |=> q.edr[gp][EDR_PID_LSB +: 8] == 8'h00
             && q.edr[gp][EDR_ATTR_LSB +: 3] == ATTR_SUPER_DATA)
         else $error("Non-core fault fields wrong");

      AST_PORT_DIR: assert property (@(posedge clk) disable iff (!rst_n)
         err[gp] |=> q.edr[gp][EDR_DIR_BIT] == $past(port_ref[gp].write))
         else $error("Direction bit wrong");
   end : g_port_chk

   // Every descriptor: start/end side effects and read-back forms
   for (genvar gr = 0; gr < NUM_REGIONS; gr++) begin : g_rgn_chk
      localparam logic [11:0] RGN_OFF = RGD_BASE + 12'(gr) * RGD_STRIDE;

      AST_RGN_CLEARS_VALID: assert property (@(posedge clk) disable iff (!rst_n)
         acc_w && (avs_address == RGN_OFF || avs_address == RGN_OFF + 12'h004)
         |=> !region_valid[gr])
         else $error("Start or end write left region valid");

      AST_RGN_LOW_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
         avs_read && avs_waitrequest
         && (avs_address == RGN_OFF || avs_address == RGN_OFF + 12'h004)
         |=> avs_readdata[ADDR_LSB-1:0] == '0)
         else $error("Address word low bits not zero");

      AST_RGN_RIGHTS_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
         avs_read && avs_waitrequest && avs_address == RGN_OFF + 12'h008 |=> avs_readdata == '0)
         else $error("Rights word not read as zero");
   end : g_rgn_chk

   COV_MISS: cover property (@(posedge clk) disable iff (!rst_n) err[0] && hit[0] == '0);
   COV_ALL_FLAGS: cover property (@(posedge clk) disable iff (!rst_n) q.flag == '1);
   COV_OVERLAP: cover property (@(posedge clk) disable iff (!rst_n)
      err[0] && $countones(hit[0] & port_deny[0]) > 1);
   COV_SET_WINS: cover property (@(posedge clk) disable iff (!rst_n)
      acc_w && avs_address == CTRL_OFF && err[0]);
   COV_IRQ: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
endmodule : mpu_err_rgn

// ### test/xbar_port_model.sv
// Purpose: Crossbar slave port model feeding references and region denials
// Assumes: One reference per port per cycle, driven just after the rising edge
// Notes: A released port shows inverted payload so stale values cannot pass
`timescale 1ns/1ps
module xbar_port_model
   import mpu_pkg::*;
(
   input wire logic clk,
   output ref_t [NUM_PORTS-1:0] port_ref,
   output logic [NUM_PORTS-1:0][NUM_REGIONS-1:0] port_deny
);
   initial begin
      port_ref = '0;
      port_deny = '0;
   end
   task put(input int p, input ref_t r, input logic [NUM_REGIONS-1:0] d);
      @(posedge clk);
      port_ref[p] <= r;
      port_deny[p] <= d;
   endtask : put
   task drop(input int p);
      ref_t r;
      r = ~port_ref[p];
      r.valid = 1'b0;
      @(posedge clk);
      port_ref[p] <= r;
      port_deny[p] <= ~port_deny[p];
   endtask : drop
endmodule : xbar_port_model

// ### test/tb_mpu_err_rgn.sv
// Purpose: Self-checking bench for error capture and region start/end words
// Assumes: Bus answer time read from waitrequest, references idle during bus reads
// Notes: Expected capture records come from an integer model of the regions
`timescale 1ns/1ps
module tb_mpu_err_rgn
   import mpu_pkg::*;
;
   logic clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
   logic [ADDR_W-1:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, d;
   logic [3:0] avs_byteenable;
   logic [1:0] avs_response, rs;
   ref_t [NUM_PORTS-1:0] port_ref;
   logic [NUM_PORTS-1:0][NUM_REGIONS-1:0] port_deny;
   logic [NUM_PORTS-1:0] port_fault, flg;
   logic [NUM_REGIONS-1:0] region_valid, hit, dn;
   logic [31:0] ear_m[NUM_PORTS], edr_m[NUM_PORTS];
   int rs_m[NUM_REGIONS], re_m[NUM_REGIONS], rv_m[NUM_REGIONS];
   int err_total, checks, cyc, p, s_t[3], e_t[3];
   ref_t r;
   logic flt, core;
   logic [2:0] at;
   logic [3:0] be;
   mpu_err_rgn mpu_err_rgn_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
      .port_ref(port_ref), .port_deny(port_deny), .port_fault(port_fault),
      .region_valid(region_valid), .irq(irq));
   xbar_port_model xbar_port_model_i (.clk(clk), .port_ref(port_ref), .port_deny(port_deny));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task results();
      $display("Comparisons %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : results
   // Hang guard, run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         results();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask : chk
   // Request held until waitrequest is sampled low at a rising edge; data taken there
   task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= wd;
      avs_byteenable <= be;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      rs = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // Write lands at that edge; callers look at outputs only once it has settled
      @(negedge clk);
   endtask : bus
   task rd_chk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(d, exp);
      chk(rs, RESP_OK);
   endtask : rd_chk
   initial begin
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hf;
      be = 4'hf;
      rst_n = 1'b0;
      s_t = '{32'h0, 32'h80, 32'h300};
      e_t = '{32'hff, 32'h1ff, 32'h3ff};
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      void'($urandom(89000));
      rd_chk(CTRL_OFF, 32'h0);
      rd_chk(ERR_BASE + EDR_SUB, 32'h0);
      bus(1'b0, 12'h800, 32'h0);
      chk(rs, RESP_SLVERR);
      for (int g = 0; g < NUM_REGIONS; g++) rv_m[g] = 0;
      for (int g = 0; g < 3; g++) begin
         bus(1'b1, RGD_BASE + 12'(16 * g), s_t[g]);
         bus(1'b1, RGD_BASE + 12'(16 * g + 4), e_t[g] & 32'hffffffe0);
         bus(1'b1, RGD_BASE + 12'(16 * g + 12), 32'h1);
         rs_m[g] = s_t[g] >> 5;
         re_m[g] = e_t[g] >> 5;
         rv_m[g] = 1;
      end
      chk(region_valid, 8'h07);
      rd_chk(RGD_BASE, 32'h0);
      rd_chk(RGD_BASE + 12'h010, 32'h80);
      rd_chk(RGD_BASE + 12'h014, 32'h1e0);
      rd_chk(RGD_BASE + 12'h008, 32'h0);
      bus(1'b1, 12'h43c, 32'h1);
      chk(region_valid[3], 1'b1);
      bus(1'b1, 12'h430, 32'hffffffff);
      chk(region_valid[3], 1'b0);
      rd_chk(12'h430, 32'hffffffe0);
      bus(1'b1, 12'h43c, 32'h1);
      bus(1'b1, 12'h434, 32'h1f);
      chk(region_valid[3], 1'b0);
      rd_chk(12'h434, 32'h0);
      r = '0;
      r.valid = 1'b1;
      xbar_port_model_i.put(0, r, 8'hff);
      @(negedge clk);
      chk(port_fault, 4'h0);
      xbar_port_model_i.drop(0);
      rd_chk(CTRL_OFF, 32'h0);
      bus(1'b1, CTRL_OFF, 32'h1);
      bus(1'b1, IRQ_EN_OFF, 32'hf);
      flg = '0;
      for (int i = 0; i < 30; i++) begin
         p = $urandom_range(0, NUM_PORTS - 1);
         r = ref_t'(48'({$urandom, $urandom}));
         r.valid = 1'b1;
         r.addr = $urandom_range(0, 32'h47f) | (r.addr & 32'h3);
         dn = 8'($urandom);
         for (int g = 0; g < NUM_REGIONS; g++)
            hit[g] = rv_m[g] != 0 && int'(r.addr >> 5) >= rs_m[g] && int'(r.addr >> 5) <= re_m[g];
         flt = ((hit & ~dn) == '0);
         xbar_port_model_i.put(p, r, dn);
         @(negedge clk);
         chk(port_fault[p], flt);
         xbar_port_model_i.drop(p);
         if (flt) begin
            core = r.master < CORE_MASTERS;
            at = core ? {1'b0, r.supervisor, ~r.instr} : ATTR_SUPER_DATA;
            ear_m[p] = r.addr;
            edr_m[p] = {8'h0, hit & dn, core ? r.pid : 8'h0, r.master, at, r.write};
            flg[p] = 1'b1;
            rd_chk(ERR_BASE + 12'(8 * p), ear_m[p]);
            rd_chk(ERR_BASE + 12'(8 * p) + EDR_SUB, edr_m[p]);
         end
         rd_chk(CTRL_OFF, {4'h0, flg, 24'h1});
         chk(irq, |flg);
      end
      bus(1'b1, IRQ_EN_OFF, 32'h0);
      chk(irq, 1'b0);
      bus(1'b1, IRQ_EN_OFF, 32'hf);
      chk(irq, |flg);
      bus(1'b1, CTRL_OFF, 32'h0f000001);
      rd_chk(CTRL_OFF, 32'h1);
      // Fault on port 0 stands in the very cycle the clearing write lands
      r = '0;
      r.valid = 1'b1;
      r.addr = 32'h40;
      fork
         bus(1'b1, CTRL_OFF, 32'h01000001);
         begin
            @(posedge clk);
            xbar_port_model_i.put(0, r, 8'hff);
            xbar_port_model_i.drop(0);
         end
      join
      rd_chk(CTRL_OFF, 32'h01000001);
      rd_chk(ERR_BASE, 32'h40);
      rd_chk(ERR_BASE + EDR_SUB, 32'h00010002);
      // Lane 3 masked, so the flag clear must not reach the flags
      be = 4'h1;
      bus(1'b1, CTRL_OFF, 32'h0f000001);
      be = 4'hf;
      rd_chk(CTRL_OFF, 32'h01000001);
      bus(1'b1, CTRL_OFF, 32'h0f000001);
      rd_chk(CTRL_OFF, 32'h1);
      bus(1'b1, IRQ_CLR_OFF, 32'hf);
      chk(irq, 1'b0);
      rd_chk(IRQ_STAT_OFF, 32'h0);
      results();
   end
endmodule : tb_mpu_err_rgn
